// ### hbd_drive_decoder.sv
// h-bridge drive decoder: two control inputs to the four gate states
// assumes pins asynchronous to clk_i, wishbone master on clk_i
//
// The Wishbone interface to the registers and the register addresses were decided locally.
module hbd_drive_decoder #(
    parameter logic [7:0] DEGLITCH_CYC = 8'(hbd_pkg::DEGLITCH_CYC)
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // control pins
    input wire logic pin_input_a_i,
    input wire logic pin_input_b_i,
    input wire logic sleep_n_i,
    // gate drives of the two legs
    output logic bridge_out_a_hs_o,
    output logic bridge_out_a_ls_o,
    output logic bridge_out_b_hs_o,
    output logic bridge_out_b_ls_o
);

    localparam int NPIN = 3;
    localparam int PIN_A = 0;
    localparam int PIN_B = 1;
    localparam int PIN_SLEEP = 2;

    // leg target from the decoded inputs; leg_b selects the second leg
    function automatic hbd_pkg::hbd_leg_e leg_target(
        input logic awake,
        input logic scheme,
        input logic in_a,
        input logic in_b,
        input logic leg_b
    );
        hbd_pkg::hbd_leg_e t;
        t = hbd_pkg::HBD_LEG_OFF;
        if (!awake) begin
            t = hbd_pkg::HBD_LEG_OFF;
        end else if (!scheme) begin
            // in_a is enable, in_b is phase
            if (!in_a) begin
                t = hbd_pkg::HBD_LEG_LOW;
            end else if (in_b ^ leg_b) begin
                t = hbd_pkg::HBD_LEG_HIGH;
            end else begin
                t = hbd_pkg::HBD_LEG_LOW;
            end
        end else begin
            unique case ({in_a, in_b})
                2'b00: t = hbd_pkg::HBD_LEG_OFF;
                2'b10: t = leg_b ? hbd_pkg::HBD_LEG_LOW : hbd_pkg::HBD_LEG_HIGH;
                2'b01: t = leg_b ? hbd_pkg::HBD_LEG_HIGH : hbd_pkg::HBD_LEG_LOW;
                2'b11: t = hbd_pkg::HBD_LEG_LOW;
            endcase
        end
        return t;
    endfunction

    // pin synchronisers
    logic [NPIN-1:0] pins_raw;
    logic [NPIN-1:0] meta_reg;
    logic [NPIN-1:0] meta_next;
    logic [NPIN-1:0] sync_reg;
    logic [NPIN-1:0] sync_next;

    assign pins_raw = {sleep_n_i, pin_input_b_i, pin_input_a_i};

    always_comb begin
        meta_next = pins_raw;
        sync_next = meta_reg;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    // deglitch: a level must stand for DEGLITCH_CYC cycles to be taken
    // reset value 0 keeps the bridge asleep until sleep_n is seen high
    logic [NPIN-1:0] filt_reg;
    logic [NPIN-1:0] filt_next;
    logic [7:0] dg_cnt_reg [NPIN];
    logic [7:0] dg_cnt_next [NPIN];

    genvar gp;
    generate
        for (gp = 0; gp < NPIN; gp++) begin : g_deglitch
            always_comb begin
                filt_next[gp] = filt_reg[gp];
                dg_cnt_next[gp] = 8'h00;
                if (sync_reg[gp] != filt_reg[gp]) begin
                    if (dg_cnt_reg[gp] >= DEGLITCH_CYC - 8'h01) begin
                        filt_next[gp] = sync_reg[gp];
                    end else begin
                        dg_cnt_next[gp] = dg_cnt_reg[gp] + 8'h01;
                    end
                end
            end

            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    filt_reg[gp] <= 1'b0;
                    dg_cnt_reg[gp] <= 8'h00;
                end else begin
                    filt_reg[gp] <= filt_next[gp];
                    dg_cnt_reg[gp] <= dg_cnt_next[gp];
                end
            end
        end
    endgenerate

    // software registers and bus slave
    logic [3:0] ctrl_reg;
    logic [3:0] ctrl_next;
    logic [7:0] gap_reg;
    logic [7:0] gap_next;
    logic ack_reg;
    logic ack_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic [31:0] status_word;
    logic bus_req;

    // leg state, declared here for the status word
    hbd_pkg::hbd_leg_e leg_reg [2];
    hbd_pkg::hbd_leg_e leg_next [2];
    logic [7:0] gap_cnt_reg [2];
    logic [7:0] gap_cnt_next [2];

    logic source_sel;
    logic scheme_sel;
    logic sel_a;
    logic sel_b;
    logic awake;

    assign source_sel = ctrl_reg[hbd_pkg::CTRL_SOURCE_SEL_BIT];
    assign scheme_sel = ctrl_reg[hbd_pkg::CTRL_SCHEME_SEL_BIT];
    assign awake = filt_reg[PIN_SLEEP];
    // the pin path is filtered and software bits are not: a source switch
    // only changes outputs through the leg sequencer, never as a raw glitch
    assign sel_a = source_sel ? ctrl_reg[hbd_pkg::CTRL_SW_A_BIT] : filt_reg[PIN_A];
    assign sel_b = source_sel ? ctrl_reg[hbd_pkg::CTRL_SW_B_BIT] : filt_reg[PIN_B];

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[hbd_pkg::STAT_AWAKE_BIT] = awake;
        status_word[hbd_pkg::STAT_PIN_A_BIT] = filt_reg[PIN_A];
        status_word[hbd_pkg::STAT_PIN_B_BIT] = filt_reg[PIN_B];
        status_word[hbd_pkg::STAT_SEL_A_BIT] = sel_a;
        status_word[hbd_pkg::STAT_SEL_B_BIT] = sel_b;
        status_word[hbd_pkg::STAT_LEG_A_LSB +: 3] = leg_reg[0];
        status_word[hbd_pkg::STAT_LEG_B_LSB +: 3] = leg_reg[1];
    end

    // one wait cycle: ack rises the cycle after the request, drops after
    assign bus_req = wb_cyc_i & wb_stb_i & ~ack_reg;

    always_comb begin
        ctrl_next = ctrl_reg;
        gap_next = gap_reg;
        ack_next = bus_req;
        rdata_next = 32'h0000_0000;
        if (bus_req) begin
            if (wb_we_i) begin
                if (wb_adr_i[7:2] == hbd_pkg::CTRL_OFS[7:2] && wb_sel_i[0]) begin
                    ctrl_next = wb_dat_i[3:0];
                end
                if (wb_adr_i[7:2] == hbd_pkg::GAP_OFS[7:2] && wb_sel_i[0]) begin
                    gap_next = wb_dat_i[7:0];
                end
            end else begin
                if (wb_adr_i[7:2] == hbd_pkg::CTRL_OFS[7:2]) begin
                    rdata_next = {28'h0000000, ctrl_reg};
                end else if (wb_adr_i[7:2] == hbd_pkg::STATUS_OFS[7:2]) begin
                    rdata_next = status_word;
                end else if (wb_adr_i[7:2] == hbd_pkg::GAP_OFS[7:2]) begin
                    rdata_next = {24'h000000, gap_reg};
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= hbd_pkg::CTRL_RESET;
            gap_reg <= hbd_pkg::GAP_RESET;
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ctrl_reg <= ctrl_next;
            gap_reg <= gap_next;
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    // leg sequencers: a driven leg always passes through off, and off
    // is held for the gap before the opposite switch may turn on;
    // pwm is followed while each level outlasts the deglitch time and the gap, each edge paying one gap
    hbd_pkg::hbd_leg_e leg_want [2];

    genvar gl;
    generate
        for (gl = 0; gl < 2; gl++) begin : g_leg
            assign leg_want[gl] = leg_target(awake, scheme_sel, sel_a, sel_b, gl == 1);

            always_comb begin
                leg_next[gl] = leg_reg[gl];
                gap_cnt_next[gl] = gap_cnt_reg[gl];
                if (leg_reg[gl] != hbd_pkg::HBD_LEG_OFF) begin
                    if (leg_want[gl] != leg_reg[gl]) begin
                        // switch off at once, then wait out the gap
                        leg_next[gl] = hbd_pkg::HBD_LEG_OFF;
                        gap_cnt_next[gl] = gap_reg;
                    end
                end else begin
                    if (gap_cnt_reg[gl] != 8'h00) begin
                        gap_cnt_next[gl] = gap_cnt_reg[gl] - 8'h01;
                    end else if (leg_want[gl] != hbd_pkg::HBD_LEG_OFF) begin
                        leg_next[gl] = leg_want[gl];
                    end
                end
            end

            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    leg_reg[gl] <= hbd_pkg::HBD_LEG_OFF;
                    gap_cnt_reg[gl] <= 8'h00;
                end else begin
                    leg_reg[gl] <= leg_next[gl];
                    gap_cnt_reg[gl] <= gap_cnt_next[gl];
                end
            end
        end
    endgenerate

    // one-hot state bits are the gate drives themselves
    assign bridge_out_a_hs_o = leg_reg[0][1];
    assign bridge_out_a_ls_o = leg_reg[0][2];
    assign bridge_out_b_hs_o = leg_reg[1][1];
    assign bridge_out_b_ls_o = leg_reg[1][2];

endmodule

// ### hbd_pkg.sv
// constants, register map and leg states of the h-bridge drive decoder
// assumes a single 40 MHz clock and a 32-bit classic wishbone register bus
package hbd_pkg;

    localparam int unsigned CLK_KHZ = 40000;

    // crossover gap and input deglitch times, in ns
    localparam int unsigned CROSSOVER_GAP_NS = 500;
    localparam int unsigned DEGLITCH_NS = 200;
    // least times: round up to whole cycles
    localparam int unsigned CROSSOVER_GAP_CYC = (CROSSOVER_GAP_NS * CLK_KHZ + 999999) / 1000000;
    localparam int unsigned DEGLITCH_CYC = (DEGLITCH_NS * CLK_KHZ + 999999) / 1000000;

    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] GAP_OFS = 8'h08;

    // control register fields
    localparam int unsigned CTRL_SOURCE_SEL_BIT = 0;
    localparam int unsigned CTRL_SCHEME_SEL_BIT = 1;
    localparam int unsigned CTRL_SW_A_BIT = 2;
    localparam int unsigned CTRL_SW_B_BIT = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;

    // status register fields
    localparam int unsigned STAT_AWAKE_BIT = 0;
    localparam int unsigned STAT_PIN_A_BIT = 1;
    localparam int unsigned STAT_PIN_B_BIT = 2;
    localparam int unsigned STAT_SEL_A_BIT = 3;
    localparam int unsigned STAT_SEL_B_BIT = 4;
    localparam int unsigned STAT_LEG_A_LSB = 8;
    localparam int unsigned STAT_LEG_B_LSB = 12;

    // gap register: crossover gap length in clock cycles, minus one
    localparam logic [7:0] GAP_RESET = 8'(CROSSOVER_GAP_CYC);

    // one leg of the bridge: both switches off, high side on, low side on
    typedef enum logic [2:0] {
        HBD_LEG_OFF = 3'b001,
        HBD_LEG_HIGH = 3'b010,
        HBD_LEG_LOW = 3'b100
    } hbd_leg_e;

endpackage

// ### hbd_mcu_model.sv
// controller model driving the decoder's control pins
// assumes the bench calls its tasks from the main sequence on clk_i
module hbd_mcu_model (
    input wire logic clk_i,
    output logic pin_a_o,
    output logic pin_b_o,
    output logic sleep_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        pin_a_o = 1'b0;
        pin_b_o = 1'b0;
        sleep_n_o = 1'b1;
    end
    // static levels, changed only after an edge
    task set_pins(input logic a, input logic b);
        @(posedge clk_i);
        pin_a_o <= a;
        pin_b_o <= b;
    endtask
    // short spike well under the filter length, far below 200 ns
    task pulse_b(input int n);
        @(posedge clk_i);
        pin_b_o <= ~pin_b_o;
        repeat (n) @(posedge clk_i);
        pin_b_o <= ~pin_b_o;
    endtask
    task set_sleep(input logic s);
        @(posedge clk_i);
        sleep_n_o <= s;
    endtask
endmodule

// ### hbd_checker.sv
// bus and gate-drive assertions for the drive decoder
// assumes a bind onto hbd_drive_decoder, names as its ports
module hbd_checker #(
    parameter logic [7:0] DEGLITCH_CYC = 8'h08
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic sleep_n_i,
    input wire logic bridge_out_a_hs_o,
    input wire logic bridge_out_a_ls_o,
    input wire logic bridge_out_b_hs_o,
    input wire logic bridge_out_b_ls_o
);
    logic [7:0] slp_reg;
    logic [7:0] slp_next;
    logic a_on;
    logic b_on;
    assign a_on = bridge_out_a_hs_o | bridge_out_a_ls_o;
    assign b_on = bridge_out_b_hs_o | bridge_out_b_ls_o;
    // saturating count of cycles with the sleep pin low
    always_comb begin
        slp_next = (slp_reg == 8'hFF) ? slp_reg : slp_reg + 8'h01;
        if (sleep_n_i) begin
            slp_next = 8'h00;
        end
    end
    always_ff @(posedge clk_i) begin
        slp_reg <= rst_i ? 8'h00 : slp_next;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_leg_a_safe: assert property (!(bridge_out_a_hs_o && bridge_out_a_ls_o))
        else $error("leg a both switches on");
    chk_leg_b_safe: assert property (!(bridge_out_b_hs_o && bridge_out_b_ls_o))
        else $error("leg b both switches on");
    chk_gap_a_off: assert property ($rose(a_on) || $changed(bridge_out_a_hs_o) && a_on |-> !$past(a_on))
        else $error("leg a switched without an off cycle");
    chk_gap_b_off: assert property ($rose(b_on) || $changed(bridge_out_b_hs_o) && b_on |-> !$past(b_on))
        else $error("leg b switched without an off cycle");
    chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked next cycle");
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    chk_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    chk_sleep_off: assert property (slp_reg > DEGLITCH_CYC + 8'h05 |-> !a_on && !b_on)
        else $error("bridge driven while asleep");
    cover property (bridge_out_a_hs_o && bridge_out_b_ls_o);
    cover property (bridge_out_a_ls_o && bridge_out_b_hs_o);
    cover property (bridge_out_a_ls_o && bridge_out_b_ls_o);
endmodule
bind hbd_drive_decoder hbd_checker #(.DEGLITCH_CYC(DEGLITCH_CYC)) u_chk (.*);

// ### tb_top.sv
// self-checking bench for the h-bridge drive decoder
// assumes hbd_mcu_model on the pins and the bound checker
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] rd;
    logic ack, pa, pb, sl, ahs, als, bhs, bls;
    logic [3:0] legs;
    int n_mismatch = 0;
    int samples_checked = 0;
    assign legs = {ahs, als, bhs, bls};
    hbd_mcu_model u_mcu (.clk_i(clk_i), .pin_a_o(pa), .pin_b_o(pb), .sleep_n_o(sl));
    hbd_drive_decoder u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .pin_input_a_i(pa), .pin_input_b_i(pb), .sleep_n_i(sl),
        .bridge_out_a_hs_o(ahs), .bridge_out_a_ls_o(als), .bridge_out_b_hs_o(bhs),
        .bridge_out_b_ls_o(bls));
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
    endtask
    // {a hs, a ls, b hs, b ls}
    function automatic logic [3:0] exp_legs(input logic sch, input logic a, input logic b);
        if (!sch) return a ? (b ? 4'h9 : 4'h6) : 4'h5;
        return (a && b) ? 4'h5 : a ? 4'h9 : b ? 4'h6 : 4'h0;
    endfunction
    task settle;
        repeat (40) @(posedge clk_i);
    endtask
    task t_regs;
        bus(1'b0, 8'h00, 32'h0);
        check("ctrl", rd, 32'h0);
        bus(1'b0, 8'h08, 32'h0);
        check("gap", rd, 32'h14);
        bus(1'b1, 8'h08, 32'h3);
        bus(1'b0, 8'h08, 32'h0);
        check("gap", rd, 32'h3);
        bus(1'b0, 8'h3C, 32'h0);
        check("unmapped", rd, 32'h0);
    endtask
    task t_src(input logic pins);
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, 8'h00, {28'h0, i[0], i[1], i[2], !pins});
            if (pins) u_mcu.set_pins(i[1], i[0]);
            settle;
            check("legs", legs, exp_legs(i[2], i[1], i[0]));
        end
    endtask
    task t_glitch;
        bus(1'b1, 8'h00, 32'h0);
        u_mcu.set_pins(1'b1, 1'b1);
        settle;
        u_mcu.pulse_b(3);
        repeat (30) begin
            @(posedge clk_i);
            check("legs", legs, 32'h9);
        end
    endtask
    task t_gap;
        int n;
        n = 0;
        bus(1'b1, 8'h00, 32'hD);
        settle;
        bus(1'b1, 8'h00, 32'h5);
        for (int k = 0; k < 10 && ahs; k++) @(posedge clk_i);
        while (!ahs && !als && n < 50) begin
            n++;
            @(posedge clk_i);
        end
        check("gap", n, 32'h4);
        check("legs", legs, 32'h6);
    endtask
    task t_sleep;
        u_mcu.set_sleep(1'b0);
        settle;
        check("legs", legs, 32'h0);
        u_mcu.set_sleep(1'b1);
        settle;
        check("legs", legs, 32'h6);
    endtask
    task finish_test;
        $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        finish_test;
    end
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs;
        t_src(1'b0);
        t_src(1'b1);
        t_glitch;
        t_gap;
        t_sleep;
        finish_test;
    end
endmodule
